// ### inc/rcs_pkg.sv
// Constants, offsets and codes shared by the receiver setting command block.
package rcs_pkg;

  // ==========================================================================
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_FRAME   = 8'h00;
  localparam logic [7:0] OFF_OPCODE  = 8'h04;
  localparam logic [7:0] OFF_ARG0    = 8'h08;
  localparam logic [7:0] OFF_ARG1    = 8'h0c;
  localparam logic [7:0] OFF_ARG2    = 8'h10;
  localparam logic [7:0] OFF_NAMEFLG = 8'h14;
  localparam logic [7:0] OFF_REPLY   = 8'h18;
  localparam logic [7:0] OFF_STATE   = 8'h1c;
  localparam logic [7:0] OFF_HOLD    = 8'h20;
  localparam logic [7:0] OFF_MANFREQ = 8'h24;
  localparam logic [7:0] OFF_PTSEL   = 8'h28;
  localparam logic [7:0] OFF_PTFREQ  = 8'h2c;
  localparam logic [7:0] OFF_PTLEVEL = 8'h30;

  // ==========================================================================
  // Frame delimiters
  localparam logic [7:0] CH_OPEN  = 8'h23;
  localparam logic [7:0] CH_CLOSE = 8'h2a;

  // ==========================================================================
  // Command codes
  localparam logic [3:0] OP_SET_SMART_MARGIN     = 4'h1;
  localparam logic [3:0] OP_WRITE_LIMIT_POINT    = 4'h2;
  localparam logic [3:0] OP_NAME_AND_ACTIVATE    = 4'h3;
  localparam logic [3:0] OP_SELECT_BAND_B_INPUT  = 4'h4;
  localparam logic [3:0] OP_SET_MANUAL_FREQUENCY = 4'h5;
  localparam logic [3:0] OP_ENTER_MANUAL_MODE    = 4'h6;
  localparam logic [3:0] OP_MANUAL_WITH_DEFAULTS = 4'h7;
  localparam logic [3:0] OP_SET_MANUAL_ATTEN     = 4'h8;
  localparam logic [3:0] OP_SET_MANUAL_HOLD      = 4'h9;
  localparam logic [3:0] OP_SET_RES_BANDWIDTH    = 4'ha;

  // ==========================================================================
  // Argument limits and defaults
  localparam int          MARGIN_MIN   = -20;
  localparam int          MARGIN_MAX   = 20;
  localparam int          LIMIT_IDX_MAX = 15;
  localparam int          INPUT_SEL_MAX = 2;
  localparam int          ATTEN_MAX_DB = 45;
  localparam int          RBW_IDX_MAX  = 10;
  localparam int          HOLD_MIN_MS  = 1;
  localparam int          HOLD_MAX_MS  = 30000;
  localparam logic [31:0] FREQ_MIN_HZ  = 32'h0000_2328;
  localparam logic [31:0] FREQ_MAX_HZ  = 32'hb2d0_5e00;
  localparam logic [3:0]  RBW_AUTO_IDX = 4'h0;
  localparam logic [5:0]  DEF_MIN_ATTEN_DB = 6'h0a;
  localparam logic [15:0] DEF_HOLD_MS  = 16'h03e8;
  localparam logic [1:0]  INPUT_COAX   = 2'h0;

endpackage : rcs_pkg

// ### inc/rcs_ifs.sv
// Interfaces between the bus slave, the interpreter core and the point memory.
`timescale 1ns/10ps

interface rcs_reg_if;
  logic        wr;
  logic [7:0]  wr_addr;
  logic [31:0] wdata;
  logic [7:0]  rd_addr;
  logic [31:0] rdata;
  modport slave (output wr, wr_addr, wdata, rd_addr, input rdata);
  modport core  (input wr, wr_addr, wdata, rd_addr, output rdata);
endinterface : rcs_reg_if

interface rcs_mem_if #(parameter int AW = 4, parameter int DW = 48);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport user (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface : rcs_mem_if

// ### rtl/rcs_limit_mem.sv
// Custom limit point table: one write port, one registered read port.
`timescale 1ns/10ps

module rcs_limit_mem #(
  parameter int AW = 4,
  parameter int DW = 48
) (
  input  wire logic clk,
  rcs_mem_if.mem    port
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rdata_q;

  // ==========================================================================
  // Storage. The array has no reset; validity is tracked by the point count.
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
    rdata_q <= mem_q[port.raddr];
  end

  assign port.rdata = rdata_q;

endmodule : rcs_limit_mem

// ### rtl/rcs_ahb_slave.sv
// AHB-Lite slave front end with zero wait states and registered read data.
`timescale 1ns/10ps

module rcs_ahb_slave
  import rcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  rcs_reg_if.slave         regs
);

  typedef struct packed {
    logic        wpend;
    logic [7:0]  waddr;
    logic [31:0] rdata;
  } rcs_ahb_s;

  localparam rcs_ahb_s RST = '{wpend: 1'b0, waddr: 8'h00, rdata: 32'h0};

  rcs_ahb_s q;
  rcs_ahb_s d;
  logic     take;

  // ==========================================================================
  // Only whole-word transfers are decoded; others complete with no effect.
  always_comb begin
    take = hsel & hready & htrans[1] & (hsize == 3'h2);
    d = q;
    d.wpend = take & hwrite;
    if (take) begin
      d.waddr = {haddr[7:2], 2'h0};
    end
    // Read data is captured at the address phase so it stands in the data
    // phase straight from a flip-flop.
    d.rdata = (take & ~hwrite & (haddr[31:8] == 24'h0)) ? regs.rdata : 32'h0;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign regs.rd_addr = {haddr[7:2], 2'h0};
  assign regs.wr      = q.wpend;
  assign regs.wr_addr = q.waddr;
  assign regs.wdata   = hwdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = q.rdata;

endmodule : rcs_ahb_slave

// ### rtl/rcs_core.sv
// Receiver setting command interpreter with its AHB-Lite register front end.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps

// How it works
// - Smart margin accepted only from -20 to 20, else rejected.
// - Accepted margin is the smart threshold in dB below the limit.
// - Limit point carries index 0..15, frequency in Hz and level.
// - Each point stores its level in dB microvolts with its frequency.
// - Writing a point discards all points with a higher index.
// - Limit point write answers accepted or command_rejected.
// - Band B input: 0 coaxial, 1 network L1, 2 network L2.
// - Input argument above 2 is rejected and input stays unchanged.
// - Valid manual frequency is stored, enters manual mode, answers OK.
// - Enter manual mode always succeeds and answers OK.
// - Manual defaults: auto bandwidth, auto atten, 10 dB minimum, etc.
// - Manual defaults command is never refused.
// - Attenuator 0..45 dB sets value, disables auto, enters manual.
// - Negative attenuator argument turns automatic attenuation on.
// - Attenuator command answers OK when granted, rejected otherwise.
// - Hold time in ms stored, enters manual mode, answers OK or rejected.
// - Bandwidth index 1..10 selects fixed bandwidth, disables auto.
// - Bandwidth index 0 returns to automatic; answers OK or rejected.
// - Naming without a name deactivates every active limit.
// - Naming checks stored points for coherence before activating.
module rcs_core
  import rcs_pkg::*;
#(
  parameter int PT_AW = 4
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             busy,
  output logic             manual_mode,
  output logic [1:0]       input_select,
  output logic [31:0]      manual_freq_hz,
  output logic [5:0]       atten_db,
  output logic             auto_atten,
  output logic [5:0]       minimum_attenuation,
  output logic             preselector_on,
  output logic             preamp_on,
  output logic             pulse_limiter_on,
  output logic [15:0]      hold_time_ms,
  output logic [3:0]       rbw_index,
  output logic             auto_rbw,
  output logic             limit_active,
  output logic [7:0]       smart_margin_db
);

  localparam int PTW = 48;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_RD   = 4'b0100,
    ST_CHK  = 4'b1000
  } rcs_state_e;

  typedef struct packed {
    rcs_state_e  st;
    logic        frame_open;
    logic [3:0]  opcode;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic [15:0] arg2;
    logic        name_flag;
    logic [3:0]  rep_op;
    logic        rep_ok;
    logic        rep_valid;
    logic [7:0]  margin;
    logic [4:0]  npts;
    logic        active;
    logic [1:0]  insel;
    logic [31:0] man_freq;
    logic        manual;
    logic [5:0]  att;
    logic        auto_att;
    logic [5:0]  min_att;
    logic        presel;
    logic        preamp;
    logic        pulse_lim;
    logic [15:0] hold;
    logic [3:0]  rbw;
    logic        auto_rbw;
    logic [3:0]  walk;
    logic [31:0] prev_freq;
    logic [3:0]  ptsel;
  } rcs_core_s;

  localparam rcs_core_s RST = '{
    st: ST_IDLE, frame_open: 1'b0, opcode: 4'h0, arg0: 32'h0,
    arg1: 32'h0, arg2: 16'h0, name_flag: 1'b0, rep_op: 4'h0,
    rep_ok: 1'b0, rep_valid: 1'b0, margin: 8'h00, npts: 5'h00,
    active: 1'b0, insel: INPUT_COAX, man_freq: FREQ_MIN_HZ,
    manual: 1'b0, att: DEF_MIN_ATTEN_DB, auto_att: 1'b1,
    min_att: DEF_MIN_ATTEN_DB, presel: 1'b1, preamp: 1'b0,
    pulse_lim: 1'b0, hold: DEF_HOLD_MS, rbw: RBW_AUTO_IDX,
    auto_rbw: 1'b1, walk: 4'h0, prev_freq: 32'h0, ptsel: 4'h0};

  rcs_core_s q;
  rcs_core_s d;

  rcs_reg_if regs ();
  rcs_mem_if #(.AW(PT_AW), .DW(PTW)) pts ();

  // ==========================================================================
  // Helpers
  function automatic logic in_range(input logic [31:0] v,
                                    input int lo,
                                    input int hi);
    in_range = ($signed(v) >= lo) && ($signed(v) <= hi);
  endfunction : in_range

  function automatic logic [31:0] point_freq(input logic [PTW-1:0] p);
    point_freq = p[PTW-1:16];
  endfunction : point_freq

  // ==========================================================================
  // Submodules
  rcs_ahb_slave u_bus (
    .clk       (clk),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .regs      (regs.slave)
  );

  rcs_limit_mem #(.AW(PT_AW), .DW(PTW)) u_mem (
    .clk  (clk),
    .port (pts.mem)
  );

  // ==========================================================================
  // Register read view
  always_comb begin
    case (regs.rd_addr)
      OFF_FRAME:   regs.rdata = {31'h0, q.frame_open};
      OFF_OPCODE:  regs.rdata = {28'h0, q.opcode};
      OFF_ARG0:    regs.rdata = q.arg0;
      OFF_ARG1:    regs.rdata = q.arg1;
      OFF_ARG2:    regs.rdata = {16'h0, q.arg2};
      OFF_NAMEFLG: regs.rdata = {31'h0, q.name_flag};
      OFF_REPLY:   regs.rdata = {20'h0, (q.st != ST_IDLE), q.rep_valid,
                                 q.rep_ok, 5'h00, q.rep_op};
      OFF_STATE:   regs.rdata = {q.margin, q.npts, q.active, q.insel,
                                 q.manual, q.auto_att, q.att, q.presel,
                                 q.preamp, q.pulse_lim, q.auto_rbw, q.rbw};
      OFF_HOLD:    regs.rdata = {10'h000, q.min_att, q.hold};
      OFF_MANFREQ: regs.rdata = q.man_freq;
      OFF_PTSEL:   regs.rdata = {28'h0, q.ptsel};
      OFF_PTFREQ:  regs.rdata = point_freq(pts.rdata);
      OFF_PTLEVEL: regs.rdata = {{16{pts.rdata[15]}}, pts.rdata[15:0]};
      default:     regs.rdata = 32'h0;
    endcase
  end

  // ==========================================================================
  // Interpreter
  always_comb begin
    logic        ok;
    logic        fin;
    logic [31:0] freq;
    ok   = 1'b0;
    fin  = 1'b0;
    freq = point_freq(pts.rdata);
    d    = q;
    pts.we    = 1'b0;
    pts.waddr = q.arg0[PT_AW-1:0];
    pts.wdata = {q.arg1, q.arg2};
    // The single read port is shared: the coherence walk owns it while
    // busy, otherwise software browses the table through the point select.
    pts.raddr = (q.st == ST_IDLE) ? q.ptsel : q.walk;

    // Argument registers only load inside an open frame, so a stray write
    // between frames cannot alter the next command.
    if (regs.wr) begin
      case (regs.wr_addr)
        OFF_FRAME: begin
          if (q.st == ST_IDLE) begin
            if (regs.wdata[7:0] == CH_OPEN) begin
              d.frame_open = 1'b1;
              d.rep_valid  = 1'b0;
              d.opcode     = 4'h0;
              d.name_flag  = 1'b0;
            end else if (regs.wdata[7:0] == CH_CLOSE && q.frame_open) begin
              d.frame_open = 1'b0;
              d.st         = ST_EXEC;
            end
          end
        end
        OFF_OPCODE:  if (q.frame_open) d.opcode = regs.wdata[3:0];
        OFF_ARG0:    if (q.frame_open) d.arg0 = regs.wdata;
        OFF_ARG1:    if (q.frame_open) d.arg1 = regs.wdata;
        OFF_ARG2:    if (q.frame_open) d.arg2 = regs.wdata[15:0];
        OFF_NAMEFLG: if (q.frame_open) d.name_flag = regs.wdata[0];
        OFF_PTSEL:   d.ptsel = regs.wdata[3:0];
        default: ;
      endcase
    end

    case (q.st)
      ST_IDLE: ;
      ST_EXEC: begin
        fin = 1'b1;
        case (q.opcode)
          OP_SET_SMART_MARGIN: begin
            if (in_range(q.arg0, MARGIN_MIN, MARGIN_MAX)) begin
              d.margin = q.arg0[7:0];
              ok = 1'b1;
            end
          end
          OP_WRITE_LIMIT_POINT: begin
            if (in_range(q.arg0, 0, LIMIT_IDX_MAX)) begin
              pts.we = 1'b1;
              d.npts = 5'(q.arg0[PT_AW-1:0]) + 5'h01;
              // Editing the table takes the old limit out of service
              // until it is named again.
              d.active = 1'b0;
              ok = 1'b1;
            end
          end
          OP_NAME_AND_ACTIVATE: begin
            if (!q.name_flag) begin
              d.active = 1'b0;
              ok = 1'b1;
            end else if (q.npts != 5'h00) begin
              fin = 1'b0;
              d.walk = 4'h0;
              d.st = ST_RD;
            end
          end
          OP_SELECT_BAND_B_INPUT: begin
            if (in_range(q.arg0, 0, INPUT_SEL_MAX)) begin
              d.insel = q.arg0[1:0];
              ok = 1'b1;
            end
          end
          OP_SET_MANUAL_FREQUENCY: begin
            if (q.arg1 >= FREQ_MIN_HZ && q.arg1 <= FREQ_MAX_HZ) begin
              d.man_freq = q.arg1;
              d.manual = 1'b1;
              ok = 1'b1;
            end
          end
          OP_ENTER_MANUAL_MODE: begin
            d.manual = 1'b1;
            ok = 1'b1;
          end
          OP_MANUAL_WITH_DEFAULTS: begin
            d.manual    = 1'b1;
            d.auto_rbw  = 1'b1;
            d.auto_att  = 1'b1;
            d.min_att   = DEF_MIN_ATTEN_DB;
            d.presel    = 1'b1;
            d.preamp    = 1'b0;
            d.hold      = DEF_HOLD_MS;
            d.pulse_lim = 1'b0;
            ok = 1'b1;
          end
          OP_SET_MANUAL_ATTEN: begin
            if ($signed(q.arg0) < 0) begin
              d.auto_att = 1'b1;
              d.manual = 1'b1;
              ok = 1'b1;
            end else if (in_range(q.arg0, 0, ATTEN_MAX_DB)) begin
              d.att = q.arg0[5:0];
              d.auto_att = 1'b0;
              d.manual = 1'b1;
              ok = 1'b1;
            end
          end
          OP_SET_MANUAL_HOLD: begin
            if (in_range(q.arg0, HOLD_MIN_MS, HOLD_MAX_MS)) begin
              d.hold = q.arg0[15:0];
              d.manual = 1'b1;
              ok = 1'b1;
            end
          end
          OP_SET_RES_BANDWIDTH: begin
            if (q.arg0 == 32'h0) begin
              d.auto_rbw = 1'b1;
              ok = 1'b1;
            end else if (in_range(q.arg0, 1, RBW_IDX_MAX)) begin
              d.rbw = q.arg0[3:0];
              d.auto_rbw = 1'b0;
              ok = 1'b1;
            end
          end
          default: ;
        endcase
      end
      ST_RD: d.st = ST_CHK;
      ST_CHK: begin
        // Frequencies must never fall from one point to the next.
        if (q.walk != 4'h0 && freq < q.prev_freq) begin
          fin = 1'b1;
        end else if (5'(q.walk) == q.npts - 5'h01) begin
          fin = 1'b1;
          ok = 1'b1;
          d.active = 1'b1;
        end else begin
          d.walk = q.walk + 4'h1;
          d.prev_freq = freq;
          d.st = ST_RD;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    if (fin) begin
      d.rep_op    = q.opcode;
      d.rep_ok    = ok;
      d.rep_valid = 1'b1;
      d.st        = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Receiver controls
  assign busy                = (q.st != ST_IDLE);
  assign manual_mode         = q.manual;
  assign input_select        = q.insel;
  assign manual_freq_hz      = q.man_freq;
  assign atten_db            = q.att;
  assign auto_atten          = q.auto_att;
  assign minimum_attenuation = q.min_att;
  assign preselector_on      = q.presel;
  assign preamp_on           = q.preamp;
  assign pulse_limiter_on    = q.pulse_lim;
  assign hold_time_ms        = q.hold;
  assign rbw_index           = q.rbw;
  assign auto_rbw            = q.auto_rbw;
  assign limit_active        = q.active;
  assign smart_margin_db     = q.margin;

endmodule : rcs_core

// ### dv/rcs_core_props.sv
// Concurrent checks on the ports of the receiver setting command block.
`timescale 1ns/10ps

module rcs_core_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        busy,
  input wire logic        manual_mode,
  input wire logic [1:0]  input_select,
  input wire logic [5:0]  atten_db,
  input wire logic        auto_atten,
  input wire logic [15:0] hold_time_ms,
  input wire logic [3:0]  rbw_index,
  input wire logic        auto_rbw,
  input wire logic        limit_active,
  input wire logic [7:0]  smart_margin_db
);
  // ==========================================================================
  // Bus, range and timing checks; input and hold time change, and limit and manual mode rise, only when a command retires, guarded against reset edges.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  a_read_idle: assert property (!$past(hsel && htrans[1] && hready)
    |-> hrdata == 32'h0) else $error("read data outside a data phase");
  a_margin_range: assert property ($signed(smart_margin_db) >= -20 &&
    $signed(smart_margin_db) <= 20) else $error("margin out of range");
  a_input_held: assert property ($changed(input_select) && $past(nrst)
    |-> $past(busy) && input_select <= 2'h2)
    else $error("input selection moved without a valid command");
  a_atten_fixed: assert property ($fell(auto_atten) && $past(nrst)
    |-> manual_mode && atten_db <= 6'h2d) else $error("bad fixed atten");
  a_hold_manual: assert property ($changed(hold_time_ms) && $past(nrst)
    |-> $past(busy) && manual_mode) else $error("hold time moved oddly");
  a_rbw_fixed: assert property (!auto_rbw |->
    rbw_index inside {[4'h1:4'ha]}) else $error("fixed bandwidth index bad");
  a_limit_check: assert property ($rose(limit_active) && $past(nrst)
    |-> $past(busy)) else $error("limit activated outside a command");
  a_busy_ends: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("command did not retire in time");
  a_manual_entry: assert property ($rose(manual_mode) && $past(nrst)
    |-> $past(busy)) else $error("manual mode entered outside a command");
endmodule : rcs_core_props

bind rcs_core rcs_core_props chk_u (.clk(clk), .nrst(nrst), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .busy(busy), .manual_mode(manual_mode),
  .input_select(input_select), .atten_db(atten_db), .auto_atten(auto_atten),
  .hold_time_ms(hold_time_ms), .rbw_index(rbw_index), .auto_rbw(auto_rbw),
  .limit_active(limit_active), .smart_margin_db(smart_margin_db));

// ### dv/rcs_host_model.sv
// Host model: an AHB-Lite master that frames and sends setting commands.
`timescale 1ns/10ps

module rcs_host_model
  import rcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ==========================================================================
  // Released address and data lines show the inverse so a stale value never looks valid.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~{24'h0, a};
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
    hwdata <= ~d;
  endtask : xfer
  task automatic cmd(input logic [3:0] op, input logic [31:0] a0, a1,
                     input logic [15:0] lv, input logic nm,
                     output logic [31:0] r);
    xfer(1'b1, OFF_FRAME, {24'h0, CH_OPEN}, r);
    xfer(1'b1, OFF_ARG0, a0, r);
    xfer(1'b1, OFF_ARG1, a1, r);
    xfer(1'b1, OFF_ARG2, {16'h0, lv}, r);
    xfer(1'b1, OFF_NAMEFLG, {31'h0, nm}, r);
    xfer(1'b1, OFF_OPCODE, {28'h0, op}, r);
    xfer(1'b1, OFF_FRAME, {24'h0, CH_CLOSE}, r);
    r = 32'h0;
    while (r[10] !== 1'b1) xfer(1'b0, OFF_REPLY, 32'h0, r);
  endtask : cmd
endmodule : rcs_host_model

// ### dv/testbench.sv
// Self-checking bench for the receiver setting command block.
`timescale 1ns/10ps

module testbench;
  import rcs_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, hsel, hwrite, hready, hresp, busy;
  logic        manual_mode, auto_atten, preselector_on, preamp_on, auto_rbw;
  logic        pulse_limiter_on, limit_active;
  logic [1:0]  htrans, input_select;
  logic [2:0]  hsize;
  logic [3:0]  rbw_index;
  logic [5:0]  atten_db, minimum_attenuation;
  logic [7:0]  smart_margin_db;
  logic [15:0] hold_time_ms;
  logic [31:0] haddr, hwdata, hrdata, manual_freq_hz, r;
  int          fail_count = 0, comparisons = 0, cycles = 0;
  rcs_core dut_u (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .busy(busy), .manual_mode(manual_mode), .input_select(input_select),
    .manual_freq_hz(manual_freq_hz), .atten_db(atten_db),
    .auto_atten(auto_atten), .minimum_attenuation(minimum_attenuation),
    .preselector_on(preselector_on), .preamp_on(preamp_on),
    .pulse_limiter_on(pulse_limiter_on), .hold_time_ms(hold_time_ms),
    .rbw_index(rbw_index), .auto_rbw(auto_rbw), .limit_active(limit_active),
    .smart_margin_db(smart_margin_db));
  rcs_host_model host_u (.clk(clk), .hready(hready), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // Shared compare and command helpers.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cc(input logic [3:0] op, input logic [31:0] a0, a1,
                    input logic [15:0] lv, input logic nm, input logic ok);
    logic [31:0] q;
    host_u.cmd(op, a0, a1, lv, nm, q);
    chk({q[10:9], q[3:0]}, {1'b1, ok, op});
  endtask : cc
  task automatic s_freq();
    cc(OP_SET_MANUAL_FREQUENCY, 0, 32'h0002_49f0, 0, 0, 1);
    chk({manual_mode, manual_freq_hz}, {1'b1, 32'h0002_49f0});
    cc(OP_SET_MANUAL_FREQUENCY, 0, 32'h0000_2327, 0, 0, 0);
    chk(manual_freq_hz, 32'h0002_49f0);
  endtask : s_freq
  task automatic s_margin();
    int v[5] = '{-21, 20, 21, -20, 2};
    for (int i = 0; i < 5; i++) begin
      cc(OP_SET_SMART_MARGIN, v[i], 0, 0, 0, v[i] >= -20 && v[i] <= 20);
    end
    chk(smart_margin_db, 8'h02);
  endtask : s_margin
  task automatic s_input();
    for (int n = 0; n < 4; n++) begin
      cc(OP_SELECT_BAND_B_INPUT, n, 0, 0, 0, n <= 2);
      chk(input_select, (n <= 2) ? n : 2);
    end
    host_u.xfer(1'b1, OFF_FRAME, {24'h0, CH_OPEN}, r);
    host_u.xfer(1'b1, OFF_OPCODE, {28'h0, OP_SELECT_BAND_B_INPUT}, r);
    host_u.xfer(1'b1, OFF_ARG0, 32'h0, r);
    cc(OP_ENTER_MANUAL_MODE, 0, 0, 0, 0, 1);
    chk(input_select, 2'h2);
  endtask : s_input
  task automatic s_manual();
    cc(OP_SET_MANUAL_ATTEN, 45, 0, 0, 0, 1);
    chk({auto_atten, atten_db}, {1'b0, 6'h2d});
    cc(OP_SET_MANUAL_ATTEN, 46, 0, 0, 0, 0);
    chk(atten_db, 6'h2d);
    cc(OP_SET_MANUAL_ATTEN, -1, 0, 0, 0, 1);
    chk(auto_atten, 1'b1);
    cc(OP_SET_MANUAL_ATTEN, 15, 0, 0, 0, 1);
    cc(OP_SET_MANUAL_HOLD, 1500, 0, 0, 0, 1);
    cc(OP_SET_MANUAL_HOLD, 0, 0, 0, 0, 0);
    chk(hold_time_ms, 16'h05dc);
    cc(OP_SET_RES_BANDWIDTH, 11, 0, 0, 0, 0);
    cc(OP_SET_RES_BANDWIDTH, 3, 0, 0, 0, 1);
    chk({auto_rbw, rbw_index}, 5'h03);
    cc(OP_MANUAL_WITH_DEFAULTS, 0, 0, 0, 0, 1);
    chk({auto_rbw, auto_atten, minimum_attenuation, preselector_on, preamp_on,
      pulse_limiter_on, hold_time_ms}, {2'h3, DEF_MIN_ATTEN_DB, 3'h4,
      DEF_HOLD_MS});
    cc(OP_SET_RES_BANDWIDTH, 10, 0, 0, 0, 1);
    cc(OP_SET_RES_BANDWIDTH, 0, 0, 0, 0, 1);
    chk(auto_rbw, 1'b1);
  endtask : s_manual
  task automatic s_points();
    cc(OP_NAME_AND_ACTIVATE, 0, 0, 0, 1, 0);
    cc(OP_WRITE_LIMIT_POINT, 0, 32'h0002_49f0, 16'h0042, 0, 1);
    cc(OP_WRITE_LIMIT_POINT, 1, 32'h0007_a120, 16'hfffb, 0, 1);
    cc(OP_WRITE_LIMIT_POINT, 15, 32'h004c_4b40, 16'h0038, 0, 1);
    cc(OP_WRITE_LIMIT_POINT, 16, 32'h004c_4b40, 16'h0038, 0, 0);
    host_u.xfer(1'b0, OFF_STATE, 32'h0, r);
    chk({r[23:19], limit_active}, {5'h10, 1'b0});
    host_u.xfer(1'b1, OFF_PTSEL, 32'h1, r);
    host_u.xfer(1'b0, OFF_PTLEVEL, 32'h0, r);
    chk(r, 32'hffff_fffb);
    cc(OP_WRITE_LIMIT_POINT, 1, 32'h0001_86a0, 16'h0038, 0, 1);
    host_u.xfer(1'b0, OFF_STATE, 32'h0, r);
    chk(r[23:19], 5'h02);
    cc(OP_NAME_AND_ACTIVATE, 0, 0, 0, 1, 0);
    chk(limit_active, 1'b0);
    cc(OP_WRITE_LIMIT_POINT, 1, 32'h0007_a120, 16'h0038, 0, 1);
    cc(OP_NAME_AND_ACTIVATE, 0, 0, 0, 1, 1);
    chk(limit_active, 1'b1);
    host_u.cmd(OP_NAME_AND_ACTIVATE, 0, 0, 0, 1'b0, r);
    chk({r[10], limit_active}, 2'h2);
    host_u.xfer(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0);
  endtask : s_points
  task automatic report_and_stop();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    s_freq();
    s_margin();
    s_input();
    s_manual();
    s_points();
    report_and_stop();
  end
endmodule : testbench
